// ==== design/reset_seq_pkg.sv ====
package reset_seq_pkg;
    localparam int unsigned CLK_MHZ = 125;
    localparam int unsigned PCI_RESET_MS = 1;
    localparam int unsigned COMPANION_RESET_MS = 2;
    localparam int unsigned MS_CYCLES = CLK_MHZ * 1000;
    localparam int unsigned PCI_RESET_CYCLES = PCI_RESET_MS * MS_CYCLES;
    localparam int unsigned COMPANION_RESET_CYCLES =
        COMPANION_RESET_MS * MS_CYCLES;
    localparam int unsigned INIT_HOST_CLOCKS = 4;
    localparam int unsigned BIST_EXTRA_HOST_CLOCKS = 16;
    localparam int unsigned PROC_RELEASE_HOST_CLOCKS = 2;
    localparam logic [7:0] CPU_RESET_CONTROL_OFFSET = 8'h93;
    localparam logic [7:0] CPU_RESET_CONTROL_RESET = 8'h00;
    localparam int unsigned HARD_RESET_BIT = 1;
    localparam int unsigned SOFT_RESET_BIT = 2;
    localparam int unsigned BIST_BIT = 3;
    localparam logic [7:0] CTRL_KEEP_MASK = 8'hF1;
endpackage

// ==== design/companion_reset.sv ====
`timescale 1ns/1ps
module companion_reset #(
    parameter int STRAP_W = 8
) (
    input  wire logic               ref_clk_in,          // Host clock
    input  wire logic               companion_reset_n_in, // From controller
    input  wire logic [STRAP_W-1:0] strap_in,            // Straps
    output logic                    proc_reset_o_out,    // Drive level
    output logic                    proc_reset_oe_n_out, // Low drives pin
    output logic [STRAP_W-1:0]      strap_out,           // Captured straps
    output logic                    sm_reset_out         // Internal reset
);
    logic [1:0]         rel_cnt_reg, rel_cnt_next;
    logic               drive_reg, drive_next;
    logic               prev_reg, prev_next;
    logic [STRAP_W-1:0] strap_reg, strap_next;

    always_comb begin
        prev_next  = companion_reset_n_in;
        strap_next = strap_reg;
        rel_cnt_next = rel_cnt_reg;
        drive_next = drive_reg;
        if (!companion_reset_n_in) begin
            drive_next   = 1'b1;
            rel_cnt_next = 2'h0;
        end else if (drive_reg) begin
            rel_cnt_next = rel_cnt_reg + 2'h1;
            if (rel_cnt_reg == 2'(reset_seq_pkg::PROC_RELEASE_HOST_CLOCKS - 1))
                drive_next = 1'b0;
        end
        if (companion_reset_n_in && !prev_reg)
            strap_next = strap_in;
    end

    always_ff @(posedge ref_clk_in) begin
        rel_cnt_reg <= rel_cnt_next;
        drive_reg   <= drive_next;
        prev_reg    <= prev_next;
        strap_reg   <= strap_next;
    end

    // Open drain: pull-up returns the pin high once released
    assign proc_reset_o_out    = 1'b0;
    assign proc_reset_oe_n_out = ~drive_reg;
    assign strap_out           = strap_reg;
    assign sm_reset_out        = ~companion_reset_n_in;
endmodule

// ==== design/host_bridge_reset_sequencer.sv ====
// Behaviour
// - Power-good low holds both resets
// - PCI reset 1 ms, companion 2 ms after power good
// - Companion drives processor reset while input low
// - Processor reset released two clocks after input
// - Releases synchronous to host and PCI clocks
// - Programmed hard reset: companion 2 ms, PCI 1 ms
// - Hard reset clears controller registers
// - Controller straps captured on power-good rise
// - Companion resets state, captures straps on rise
// - Shutdown cycle: no-data response and init in the same cycle
// - Programmed soft reset asserts init 4 clocks
// - Self-test: PCI 1 ms, companion 2 ms, init longer
`timescale 1ns/1ps
module host_bridge_reset_sequencer #(
    parameter int STRAP_W = 8,
    parameter int PCI_CYC = reset_seq_pkg::PCI_RESET_CYCLES,
    parameter int COMP_CYC = reset_seq_pkg::COMPANION_RESET_CYCLES
) (
    input  wire logic               ref_clk_in,          // Host/PCI clock
    input  wire logic               rst_in,              // Sync reset
    input  wire logic               power_good_in,       // Power good
    input  wire logic               shutdown_cycle_in,   // Shutdown seen
    output logic                    no_data_resp_out,    // Completion pulse
    input  wire logic               cfg_wr_in,           // Config write
    input  wire logic               cfg_rd_in,           // Config read
    input  wire logic [7:0]         cfg_addr_in,         // Config offset
    input  wire logic [7:0]         cfg_wdata_in,        // Write data
    output logic [7:0]              cfg_rdata_out,       // Read data
    input  wire logic [STRAP_W-1:0] strap_in,            // Controller straps
    output logic [STRAP_W-1:0]      strap_out,           // Captured straps
    input  wire logic [STRAP_W-1:0] comp_strap_in,       // Companion straps
    output logic [STRAP_W-1:0]      comp_strap_out,      // Captured
    output logic                    pci_bus_reset_out_n, // PCI reset
    output logic                    companion_reset_n_out, // To companion
    output logic                    proc_init_n_out,     // Processor init
    output logic                    proc_reset_o_out,    // Proc reset level
    output logic                    proc_reset_oe_n_out, // Low drives
    output logic                    comp_sm_reset_out    // Companion reset
);
    localparam int BIST_EXTRA = reset_seq_pkg::BIST_EXTRA_HOST_CLOCKS;
    // Counter spans the longest run: self-test init outlasts the companion
    localparam int CW = $clog2(COMP_CYC + BIST_EXTRA + 2);

    // Hard reset and self-test share ST_HARD; bist_reg tells them apart
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_HARD = 2'b01,
        ST_INIT = 2'b10
    } seq_e;

    seq_e               state_reg, state_next;
    logic [CW-1:0]      cnt_reg, cnt_next;
    logic               pci_rst_reg, pci_rst_next;
    logic               comp_rst_reg, comp_rst_next;
    logic               init_reg, init_next;
    logic               bist_reg, bist_next;
    logic               pg_prev_reg, pg_prev_next;
    logic [7:0]         ctrl_reg, ctrl_next;
    logic [STRAP_W-1:0] strap_reg, strap_next;
    logic               resp_reg, resp_next;
    logic [7:0]         rdata_reg, rdata_next;
    logic               ctrl_hit;

    // Only the control register is decoded; other offsets read as zero
    assign ctrl_hit = cfg_addr_in == reset_seq_pkg::CPU_RESET_CONTROL_OFFSET;

    always_comb begin
        state_next    = state_reg;
        cnt_next      = cnt_reg;
        pci_rst_next  = pci_rst_reg;
        comp_rst_next = comp_rst_reg;
        init_next     = init_reg;
        bist_next     = bist_reg;
        ctrl_next     = ctrl_reg;
        resp_next     = 1'b0;
        unique case (state_reg)
            ST_IDLE: begin
                // Requests are taken in idle only; later ones are dropped
                if (shutdown_cycle_in) begin
                    resp_next  = 1'b1;
                    init_next  = 1'b1;
                    cnt_next   = '0;
                    state_next = ST_INIT;
                end else if (cfg_wr_in && ctrl_hit) begin
                    ctrl_next = cfg_wdata_in
                        & reset_seq_pkg::CTRL_KEEP_MASK;
                    cnt_next = '0;
                    if (cfg_wdata_in[reset_seq_pkg::BIST_BIT]) begin
                        pci_rst_next  = 1'b1;
                        comp_rst_next = 1'b1;
                        init_next     = 1'b1;
                        bist_next     = 1'b1;
                        state_next    = ST_HARD;
                    end else if (cfg_wdata_in[reset_seq_pkg::HARD_RESET_BIT])
                    begin
                        pci_rst_next  = 1'b1;
                        comp_rst_next = 1'b1;
                        ctrl_next     = reset_seq_pkg::CPU_RESET_CONTROL_RESET;
                        state_next    = ST_HARD;
                    end else if (cfg_wdata_in[reset_seq_pkg::SOFT_RESET_BIT])
                    begin
                        init_next  = 1'b1;
                        state_next = ST_INIT;
                    end
                end
            end
            ST_HARD: begin
                // PCI drops first; self-test holds init past the companion
                cnt_next = cnt_reg + CW'(1);
                if (cnt_reg == CW'(PCI_CYC - 1))
                    pci_rst_next = 1'b0;
                if (cnt_reg == CW'(COMP_CYC - 1))
                    comp_rst_next = 1'b0;
                if (!bist_reg && cnt_reg == CW'(COMP_CYC - 1))
                    state_next = ST_IDLE;
                if (bist_reg && cnt_reg == CW'(COMP_CYC + BIST_EXTRA - 1))
                begin
                    init_next  = 1'b0;
                    bist_next  = 1'b0;
                    state_next = ST_IDLE;
                end
            end
            ST_INIT: begin
                // Shutdown and soft write share one fixed init width
                cnt_next = cnt_reg + CW'(1);
                if (cnt_reg == CW'(reset_seq_pkg::INIT_HOST_CLOCKS - 1)) begin
                    init_next  = 1'b0;
                    state_next = ST_IDLE;
                end
            end
            default: state_next = ST_IDLE;
        endcase
        // Power loss overrides all but the no-data response and restarts the hard sequence
        if (!power_good_in) begin
            pci_rst_next  = 1'b1;
            comp_rst_next = 1'b1;
            init_next     = 1'b0;
            bist_next     = 1'b0;
            cnt_next      = '0;
            ctrl_next     = reset_seq_pkg::CPU_RESET_CONTROL_RESET;
            state_next    = ST_HARD;
        end
    end

    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            state_reg    <= ST_HARD;
            cnt_reg      <= '0;
            pci_rst_reg  <= 1'b1;
            comp_rst_reg <= 1'b1;
            init_reg     <= 1'b0;
            bist_reg     <= 1'b0;
            ctrl_reg     <= reset_seq_pkg::CPU_RESET_CONTROL_RESET;
            resp_reg     <= 1'b0;
        end else begin
            state_reg    <= state_next;
            cnt_reg      <= cnt_next;
            pci_rst_reg  <= pci_rst_next;
            comp_rst_reg <= comp_rst_next;
            init_reg     <= init_next;
            bist_reg     <= bist_next;
            ctrl_reg     <= ctrl_next;
            resp_reg     <= resp_next;
        end
    end

    // Straps load only on a power-good rise, so programmed resets keep them
    always_comb begin
        pg_prev_next = power_good_in;
        strap_next   = strap_reg;
        if (power_good_in && !pg_prev_reg)
            strap_next = strap_in;
    end

    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            // Cleared so power good already high at release still loads
            pg_prev_reg <= 1'b0;
            strap_reg   <= '0;
        end else begin
            pg_prev_reg <= pg_prev_next;
            strap_reg   <= strap_next;
        end
    end

    // Reads answer one cycle after the strobe
    always_comb begin
        rdata_next = 8'h00;
        if (cfg_rd_in && ctrl_hit)
            rdata_next = ctrl_reg;
    end

    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            rdata_reg <= 8'h00;
        end else begin
            rdata_reg <= rdata_next;
        end
    end

    assign pci_bus_reset_out_n   = ~pci_rst_reg;
    assign companion_reset_n_out = ~comp_rst_reg;
    assign proc_init_n_out       = ~init_reg;
    assign no_data_resp_out      = resp_reg;
    assign cfg_rdata_out         = rdata_reg;
    assign strap_out             = strap_reg;

    // Companion samples the very level that leaves the controller pin
    companion_reset #(.STRAP_W(STRAP_W)) u_companion (
        .ref_clk_in          (ref_clk_in),
        .companion_reset_n_in(companion_reset_n_out),
        .strap_in            (comp_strap_in),
        .proc_reset_o_out    (proc_reset_o_out),
        .proc_reset_oe_n_out (proc_reset_oe_n_out),
        .strap_out           (comp_strap_out),
        .sm_reset_out        (comp_sm_reset_out)
    );
endmodule

// ==== dv/proc_line_model.sv ====
`timescale 1ns/1ps
module proc_line_model (
    input  wire logic oe_n_in,      // Low while companion drives
    input  wire logic drive_in,     // Driven level
    input  wire logic init_n_in,    // Controller init
    input  wire logic pci_n_in,     // Controller PCI reset
    output logic      pin_out,      // Processor reset line
    output logic      init_pin_out, // Gated init line
    output logic      pci_line_out  // PCI bus reset line
);
    // Released line floats to the pull-up level, never the last value
    assign pin_out = oe_n_in ? 1'b1 : drive_in;
    // Keyboard and port soft-reset sources stay inactive in this bench
    assign init_pin_out = init_n_in & 1'b1 & 1'b1;
    // Bridge reset output left open; no bridge, so bench asks hard resets
    assign pci_line_out = pci_n_in;
endmodule

// ==== dv/host_bridge_reset_sequencer_sva.sv ====
`timescale 1ns/1ps
module reset_seq_sva #(
    parameter int STRAP_W  = 8,
    parameter int PCI_CYC  = 10,
    parameter int COMP_CYC = 20
) (
    input wire logic               ref_clk_in,            // Clock
    input wire logic               rst_in,                // Reset
    input wire logic               power_good_in,         // Power
    input wire logic               shutdown_cycle_in,     // Shutdown
    input wire logic               no_data_resp_out,      // Completion
    input wire logic               cfg_wr_in,             // Write
    input wire logic [7:0]         cfg_addr_in,           // Offset
    input wire logic [7:0]         cfg_wdata_in,          // Data
    input wire logic [STRAP_W-1:0] strap_in,              // Straps
    input wire logic [STRAP_W-1:0] strap_out,             // Captured
    input wire logic [STRAP_W-1:0] comp_strap_in,         // Comp straps
    input wire logic [STRAP_W-1:0] comp_strap_out,        // Captured
    input wire logic               pci_bus_reset_out_n,   // PCI
    input wire logic               companion_reset_n_out, // Companion
    input wire logic               proc_init_n_out,       // Init
    input wire logic               proc_reset_oe_n_out,   // Pin
    input wire logic               comp_sm_reset_out      // State
);
    default clocking @(posedge ref_clk_in); endclocking
    default disable iff (rst_in);
    logic idle, wr_ok;
    int   pci_lo_reg, comp_lo_reg, pci_lo_next, comp_lo_next;
    assign idle = pci_bus_reset_out_n && companion_reset_n_out &&
                  proc_init_n_out && proc_reset_oe_n_out;
    assign wr_ok = cfg_wr_in && idle &&
                   cfg_addr_in == reset_seq_pkg::CPU_RESET_CONTROL_OFFSET;
    // Runs include time held by power loss, so only a floor is checked
    always_comb begin
        pci_lo_next  = pci_bus_reset_out_n ? 0 : pci_lo_reg + 1;
        comp_lo_next = companion_reset_n_out ? 0 : comp_lo_reg + 1;
    end
    always_ff @(posedge ref_clk_in) begin
        pci_lo_reg  <= pci_lo_next;
        comp_lo_reg <= comp_lo_next;
    end
    property p_pg; !power_good_in
        |=> !pci_bus_reset_out_n && !companion_reset_n_out; endproperty
    a_pg: assert property (p_pg) else $error("resets not held");
    property p_pci; $rose(pci_bus_reset_out_n)
        |-> pci_lo_reg >= PCI_CYC; endproperty
    a_pci: assert property (p_pci) else $error("pci short");
    property p_comp; $rose(companion_reset_n_out)
        |-> comp_lo_reg >= COMP_CYC; endproperty
    a_comp: assert property (p_comp) else $error("comp short");
    property p_hold; !companion_reset_n_out
        |=> !proc_reset_oe_n_out; endproperty
    a_hold: assert property (p_hold) else $error("line freed");
    property p_rel; $rose(companion_reset_n_out) |-> ##1
        !proc_reset_oe_n_out ##[1:2] proc_reset_oe_n_out; endproperty
    a_rel: assert property (p_rel) else $error("bad release");
    property p_sm; !companion_reset_n_out && !$past(companion_reset_n_out)
        |-> comp_sm_reset_out; endproperty
    a_sm: assert property (p_sm) else $error("state not reset");
    property p_strap; $rose(power_good_in)
        |=> strap_out == $past(strap_in); endproperty
    a_strap: assert property (p_strap) else $error("straps missed");
    property p_cstrap; $rose(companion_reset_n_out)
        |=> comp_strap_out == $past(comp_strap_in); endproperty
    a_cstrap: assert property (p_cstrap) else $error("comp straps");
    property p_shut; shutdown_cycle_in && idle |=> no_data_resp_out &&
        !proc_init_n_out ##1 !proc_init_n_out [*3] ##1 proc_init_n_out;
    endproperty
    a_shut: assert property (p_shut) else $error("shutdown init");
    property p_soft; wr_ok && cfg_wdata_in[3:1] == 3'b010
        |=> !proc_init_n_out [*4] ##1 proc_init_n_out; endproperty
    a_soft: assert property (p_soft) else $error("soft init");
    property p_bist; wr_ok && cfg_wdata_in[3] |-> ##[1:2]
        !pci_bus_reset_out_n && !companion_reset_n_out && !proc_init_n_out;
    endproperty
    a_bist: assert property (p_bist) else $error("self-test");
    c_hard: cover property (wr_ok && cfg_wdata_in[3:1] == 3'b001);
    c_shut: cover property (shutdown_cycle_in && idle);
    c_bist: cover property (wr_ok && cfg_wdata_in[3]);
endmodule
bind host_bridge_reset_sequencer reset_seq_sva #(.STRAP_W(STRAP_W),
    .PCI_CYC(PCI_CYC), .COMP_CYC(COMP_CYC)) u_sva (.ref_clk_in, .rst_in,
    .power_good_in, .shutdown_cycle_in, .no_data_resp_out, .cfg_wr_in,
    .cfg_addr_in, .cfg_wdata_in, .strap_in, .strap_out, .comp_strap_in,
    .comp_strap_out, .pci_bus_reset_out_n, .companion_reset_n_out,
    .proc_init_n_out, .proc_reset_oe_n_out, .comp_sm_reset_out);

// ==== dv/tb_host_bridge_reset_sequencer.sv ====
`timescale 1ns/1ps
module tb_host_bridge_reset_sequencer;
    localparam int PCI = 10;
    localparam int COMP = 20;
    logic ref_clk_in = 0, rst_in = 1, power_good_in = 0;
    logic shutdown_cycle_in = 0, cfg_wr_in = 0, cfg_rd_in = 0;
    logic [7:0] cfg_addr_in = 0, cfg_wdata_in = 0, q;
    logic [7:0] strap_in = 8'hA5, comp_strap_in = 8'h5A;
    logic [7:0] cfg_rdata_out, strap_out, comp_strap_out;
    logic no_data_resp_out, pci_bus_reset_out_n, companion_reset_n_out;
    logic proc_init_n_out, proc_reset_o_out, proc_reset_oe_n_out;
    logic comp_sm_reset_out, pin, init_pin, pci_line;
    logic [2:0] mon;
    int n_mismatch = 0, cmp_count = 0, cyc = 0, n_nodata = 0;
    int run[3] = '{0, 0, 0}, len[3] = '{0, 0, 0};
    always #4 ref_clk_in = ~ref_clk_in;
    host_bridge_reset_sequencer #(.PCI_CYC(PCI), .COMP_CYC(COMP)) dut (
        .ref_clk_in, .rst_in, .power_good_in, .shutdown_cycle_in,
        .no_data_resp_out, .cfg_wr_in, .cfg_rd_in, .cfg_addr_in,
        .cfg_wdata_in, .cfg_rdata_out, .strap_in, .strap_out,
        .comp_strap_in, .comp_strap_out, .pci_bus_reset_out_n,
        .companion_reset_n_out, .proc_init_n_out, .proc_reset_o_out,
        .proc_reset_oe_n_out, .comp_sm_reset_out);
    proc_line_model far (.oe_n_in(proc_reset_oe_n_out),
        .drive_in(proc_reset_o_out), .init_n_in(proc_init_n_out),
        .pci_n_in(pci_bus_reset_out_n), .pin_out(pin),
        .init_pin_out(init_pin), .pci_line_out(pci_line));
    assign mon = {proc_init_n_out, companion_reset_n_out,
                  pci_bus_reset_out_n};
    // Length of the latest low run of the PCI, companion and init outputs
    always @(posedge ref_clk_in) begin
        cyc++;
        n_nodata += no_data_resp_out;
        for (int i = 0; i < 3; i++) begin
            if (mon[i] === 1'b0) run[i]++;
            else begin
                if (run[i] != 0) len[i] = run[i];
                run[i] = 0;
            end
        end
        if (cyc == 2000) begin
            n_mismatch++;
            print_verdict();
        end
    end
    task automatic chk(string nm, logic [7:0] seen, logic [7:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("unexpected %s: expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic acc(logic rd, logic [7:0] a, logic [7:0] d);
        @(posedge ref_clk_in);
        cfg_rd_in <= rd;
        cfg_wr_in <= !rd;
        cfg_addr_in <= a;
        cfg_wdata_in <= d;
        @(posedge ref_clk_in);
        cfg_rd_in <= 1'b0;
        cfg_wr_in <= 1'b0;
        #1 q = cfg_rdata_out;
    endtask
    task automatic settle();
        repeat (3) @(posedge ref_clk_in);
        for (int k = 0; k < 200 && {mon, pin} !== 4'hF; k++)
            @(posedge ref_clk_in);
        repeat (3) @(posedge ref_clk_in);
        #1;
    endtask
    task automatic print_verdict();
        $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    initial begin
        repeat (20) @(posedge ref_clk_in);
        rst_in <= 1'b0;
        repeat (5) @(posedge ref_clk_in);
        #1 chk("pci", pci_bus_reset_out_n, 0);
        chk("comp", companion_reset_n_out, 0);
        chk("line", pin, 0);
        chk("pci line", pci_line, 0);
        @(posedge ref_clk_in);
        power_good_in <= 1'b1;
        settle();
        chk("init line", init_pin, 1);
        @(posedge ref_clk_in);
        strap_in <= 8'h3C;
        comp_strap_in <= 8'hC3;
        acc(0, 8'h93, 8'hF1);
        acc(1, 8'h93, 8'h00);
        chk("ctrl", q, 8'hF1);
        acc(1, 8'h94, 8'h00);
        chk("unmapped", q, 8'h00);
        chk("straps", strap_out, 8'hA5);
        chk("comp straps", comp_strap_out, 8'h5A);
        acc(0, 8'h93, 8'hF2);
        settle();
        chk("pci len", 8'(len[0]), 8'(PCI));
        chk("comp len", 8'(len[1]), 8'(COMP));
        chk("comp straps", comp_strap_out, 8'hC3);
        acc(1, 8'h93, 8'h00);
        chk("ctrl", q, reset_seq_pkg::CPU_RESET_CONTROL_RESET);
        acc(0, 8'h93, 8'h04);
        settle();
        chk("soft len", 8'(len[2]), 8'h04);
        len[2] = 0;
        @(posedge ref_clk_in);
        shutdown_cycle_in <= 1'b1;
        @(posedge ref_clk_in);
        shutdown_cycle_in <= 1'b0;
        settle();
        chk("shut len", 8'(len[2]), 8'h04);
        chk("no data", 8'(n_nodata), 8'h01);
        acc(0, 8'h93, 8'h08);
        acc(0, 8'h93, 8'h04);
        settle();
        chk("bist len", 8'(len[2]), 8'(COMP + 16));
        chk("pci len", 8'(len[0]), 8'(PCI));
        chk("comp len", 8'(len[1]), 8'(COMP));
        @(posedge ref_clk_in);
        power_good_in <= 1'b0;
        strap_in <= 8'h96;
        repeat (3) @(posedge ref_clk_in);
        #1 chk("pci", pci_bus_reset_out_n, 0);
        chk("comp", companion_reset_n_out, 0);
        @(posedge ref_clk_in);
        power_good_in <= 1'b1;
        settle();
        chk("straps", strap_out, 8'h96);
        chk("pci line", pci_line, 1);
        chk("line", pin, 1);
        print_verdict();
    end
endmodule
